//--- wdg_defines.svh
// Register map, field positions, reset values and counts of the watchdog block
`ifndef WDG_DEFINES_SVH
`define WDG_DEFINES_SVH
`define WDG_PRESCALE_ADDR 8'h00
`define WDG_STATUS_ADDR 8'h04
`define WDG_PRESCALE_RST 8'h07
`define WDG_SEL_MSB 2
`define WDG_TO_BIT 5
`define WDG_PD_BIT 4
`define WDG_BASE_DIV 16'h0100
`define WDG_INSTR_LAST 2'h3
`define WDG_STARTUP_LAST 10'h3ff
`endif

//--- wdg_pkg.sv
// Types shared by the watchdog, sleep and reset-cause block
package wdg_pkg;
    typedef enum logic [1:0] {SRC_RC = 2'b00, SRC_RTC = 2'b01, SRC_INSTR = 2'b10} wdg_src_t;
    typedef enum logic [1:0] {ST_RUN = 2'b00, ST_SLEEP = 2'b01, ST_PINRST = 2'b10, ST_DELAY = 2'b11} wdg_mode_t;
    typedef enum logic [1:0] {WK_RESET = 2'b00, WK_PORT = 2'b01, WK_INT = 2'b10, WK_WARM = 2'b11} wdg_wake_t;
    typedef struct packed {
        logic hsel;
        logic [31:0] haddr;
        logic [1:0] htrans;
        logic hwrite;
        logic [2:0] hsize;
        logic [31:0] hwdata;
        logic hready;
    } wdg_ahb_req_t;
    typedef struct packed {
        logic hreadyout;
        logic hresp;
        logic [31:0] hrdata;
    } wdg_ahb_rsp_t;
    typedef struct packed {
        logic sleepInstr;
        logic kick;
        logic kickFirst;
        logic kickSecond;
    } wdg_core_cmd_t;
    typedef struct packed {
        logic [1:0] req;
        logic [1:0] enable;
        logic stackFull;
    } wdg_int_t;
    typedef struct packed {
        logic chipReset;
        logic warmReset;
        logic sleeping;
        logic coreStall;
        logic resumeNext;
        logic vectorTake;
        logic timeoutFlag;
        logic powerdownFlag;
    } wdg_core_out_t;
    typedef struct packed {
        wdg_mode_t mode;
        wdg_wake_t reason;
        logic rcMeta, rcSync, rcPrev;
        logic rtcMeta, rtcSync, rtcPrev;
        logic rstMeta, rstSync;
        logic [7:0] paMeta, paSync, paPrev;
        logic [1:0] instrDiv;
        logic [14:0] wdtCount;
        logic [7:0] prescale;
        logic firstSeen, secondSeen;
        logic [1:0] armed, wakeInt;
        logic [9:0] delayCnt;
        logic ahbValid, ahbWrite;
        logic [7:0] ahbAddr;
        wdg_ahb_rsp_t rsp;
        wdg_core_out_t out;
    } wdg_state_t;
endpackage

//--- wdg_watchdog.sv
// Watchdog counter with sleep/wake control, reset cause flags and start-up delay
//
// Register access over AHB-Lite and the placing of the registers were decided locally.
`include "wdg_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module wdg_watchdog #(
    parameter wdg_pkg::wdg_src_t CLK_SOURCE = wdg_pkg::SRC_RC,
    parameter bit RC_OSC_ENABLE = 1'b1,
    parameter bit WDT_DISABLE = 1'b0,
    parameter bit DUAL_CLEAR = 1'b0,
    parameter logic [7:0] PORTA_WAKE_MASK = 8'hff
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic clockEnable,
    input wire wdg_pkg::wdg_ahb_req_t ahbReq,
    output var wdg_pkg::wdg_ahb_rsp_t ahbRsp,
    input wire logic extResetN,
    input wire logic watchdogRcOsc,
    input wire logic realtimeCrystalOsc,
    input wire logic [7:0] portA,
    input wire wdg_pkg::wdg_core_cmd_t coreCmd,
    input wire wdg_pkg::wdg_int_t intIn,
    output var wdg_pkg::wdg_core_out_t coreOut
);
    import wdg_pkg::*;

    // RC option off falls back to the instruction clock
    localparam bit USE_INSTR = (CLK_SOURCE == SRC_INSTR) || (CLK_SOURCE == SRC_RC && !RC_OSC_ENABLE);

    wdg_state_t st;
    wdg_state_t nxt;
    logic tick;
    logic ovf;
    logic pinLow;
    logic portFall;
    logic intWake;
    logic kickClear;
    logic addrPhase;
    logic addrHit;
    logic [15:0] limitWide;
    logic [31:0] rdVal;

    assign ahbRsp = st.rsp;
    assign coreOut = st.out;

    always_comb begin
        nxt = st;
        // Oscillators and pins each pass two flops first
        nxt.rcMeta = watchdogRcOsc;
        nxt.rcSync = st.rcMeta;
        nxt.rcPrev = st.rcSync;
        nxt.rtcMeta = realtimeCrystalOsc;
        nxt.rtcSync = st.rtcMeta;
        nxt.rtcPrev = st.rtcSync;
        nxt.rstMeta = extResetN;
        nxt.rstSync = st.rstMeta;
        nxt.paMeta = portA;
        nxt.paSync = st.paMeta;
        nxt.paPrev = st.paSync;
        pinLow = !st.rstSync;
        portFall = |(st.paPrev & ~st.paSync & PORTA_WAKE_MASK);
        intWake = |(intIn.req & st.armed);

        // System clock is halted in sleep, so this divider stops too
        if (st.mode != ST_SLEEP) begin
            nxt.instrDiv = st.instrDiv + 2'h1;
        end
        if (USE_INSTR) begin
            tick = (st.instrDiv == `WDG_INSTR_LAST) && (st.mode != ST_SLEEP);
        end else if (CLK_SOURCE == SRC_RTC) begin
            tick = st.rtcSync && !st.rtcPrev;
        end else begin
            tick = st.rcSync && !st.rcPrev;
        end

        // 256 base stages then 2^n prescaler stages in one counter
        limitWide = (`WDG_BASE_DIV << st.prescale[`WDG_SEL_MSB:0]) - 16'h0001;
        ovf = !WDT_DISABLE && tick && (st.mode == ST_RUN || st.mode == ST_SLEEP)
            && (st.wdtCount == limitWide[14:0]);
        if (tick && (st.mode == ST_RUN || st.mode == ST_SLEEP)) begin
            nxt.wdtCount = st.wdtCount + 15'h0001;
        end

        nxt.out.warmReset = 1'b0;
        nxt.out.resumeNext = 1'b0;
        nxt.out.vectorTake = 1'b0;

        kickClear = 1'b0;
        if (!WDT_DISABLE && st.mode == ST_RUN) begin
            if (DUAL_CLEAR) begin
                nxt.firstSeen = st.firstSeen | coreCmd.kickFirst;
                nxt.secondSeen = st.secondSeen | coreCmd.kickSecond;
                if (nxt.firstSeen && nxt.secondSeen) begin
                    kickClear = 1'b1;
                    nxt.firstSeen = 1'b0;
                    nxt.secondSeen = 1'b0;
                end
            end else begin
                kickClear = coreCmd.kick;
            end
        end
        if (kickClear) begin
            nxt.wdtCount = '0;
            nxt.out.timeoutFlag = 1'b0;
            nxt.out.powerdownFlag = 1'b0;
        end

        // Data phase write; whole byte stored, only low bits steer
        if (st.ahbValid && st.ahbWrite && st.ahbAddr == `WDG_PRESCALE_ADDR) begin
            nxt.prescale = ahbReq.hwdata[7:0];
        end

        addrPhase = ahbReq.hsel && ahbReq.hready && ahbReq.htrans[1];
        addrHit = (ahbReq.haddr[31:8] == 24'h000000);
        nxt.ahbValid = addrPhase && addrHit;
        nxt.ahbWrite = ahbReq.hwrite;
        nxt.ahbAddr = ahbReq.haddr[7:0];
        rdVal = '0;
        if (ahbReq.haddr[7:0] == `WDG_PRESCALE_ADDR) begin
            // Forward a write still in its data phase
            if (st.ahbValid && st.ahbWrite && st.ahbAddr == `WDG_PRESCALE_ADDR) begin
                rdVal[7:0] = ahbReq.hwdata[7:0];
            end else begin
                rdVal[7:0] = st.prescale;
            end
        end else if (ahbReq.haddr[7:0] == `WDG_STATUS_ADDR) begin
            rdVal[`WDG_TO_BIT] = st.out.timeoutFlag;
            rdVal[`WDG_PD_BIT] = st.out.powerdownFlag;
        end
        if (addrPhase) begin
            nxt.rsp.hrdata = (addrHit && !ahbReq.hwrite) ? rdVal : 32'h00000000;
        end
        nxt.rsp.hreadyout = 1'b1;
        nxt.rsp.hresp = 1'b0;

        unique case (st.mode)
            ST_RUN: begin
                if (ovf) begin
                    // Overflow beats a clear in the same cycle
                    nxt.mode = ST_DELAY;
                    nxt.reason = WK_RESET;
                    nxt.out.timeoutFlag = 1'b1;
                    nxt.out.powerdownFlag = st.out.powerdownFlag;
                    nxt.prescale = `WDG_PRESCALE_RST;
                    nxt.wdtCount = '0;
                    nxt.out.chipReset = 1'b1;
                    nxt.out.coreStall = 1'b1;
                    nxt.delayCnt = '0;
                    nxt.firstSeen = 1'b0;
                    nxt.secondSeen = 1'b0;
                end else if (coreCmd.sleepInstr) begin
                    nxt.mode = ST_SLEEP;
                    nxt.out.sleeping = 1'b1;
                    nxt.wdtCount = '0;
                    nxt.out.powerdownFlag = 1'b1;
                    nxt.out.timeoutFlag = 1'b0;
                    nxt.armed = ~intIn.req;
                end
            end
            ST_SLEEP: begin
                if (ovf || portFall || intWake) begin
                    nxt.mode = ST_DELAY;
                    nxt.out.sleeping = 1'b0;
                    nxt.out.coreStall = 1'b1;
                    nxt.delayCnt = '0;
                    nxt.wdtCount = '0;
                    nxt.wakeInt = intIn.req & st.armed;
                end
                if (ovf) begin
                    nxt.reason = WK_WARM;
                    nxt.out.warmReset = 1'b1;
                    nxt.out.timeoutFlag = 1'b1;
                    nxt.out.powerdownFlag = 1'b1;
                end else if (portFall) begin
                    nxt.reason = WK_PORT;
                end else if (intWake) begin
                    nxt.reason = WK_INT;
                end
            end
            ST_PINRST: begin
                if (!pinLow) begin
                    nxt.mode = ST_DELAY;
                    nxt.reason = WK_RESET;
                    nxt.delayCnt = '0;
                end
            end
            ST_DELAY: begin
                // Counter held clear while the core is stalled
                nxt.wdtCount = '0;
                nxt.delayCnt = st.delayCnt + 10'h001;
                if (st.delayCnt == `WDG_STARTUP_LAST) begin
                    nxt.mode = ST_RUN;
                    nxt.out.coreStall = 1'b0;
                    nxt.out.chipReset = 1'b0;
                    if (st.reason == WK_PORT) begin
                        nxt.out.resumeNext = 1'b1;
                    end else if (st.reason == WK_INT) begin
                        if (|(st.wakeInt & intIn.enable) && !intIn.stackFull) begin
                            nxt.out.vectorTake = 1'b1;
                        end else begin
                            nxt.out.resumeNext = 1'b1;
                        end
                    end
                end
            end
        endcase

        if (pinLow) begin
            if (st.mode == ST_SLEEP) begin
                nxt.out.timeoutFlag = 1'b0;
                nxt.out.powerdownFlag = 1'b1;
            end
            nxt.mode = ST_PINRST;
            nxt.wdtCount = '0;
            nxt.prescale = `WDG_PRESCALE_RST;
            nxt.out.chipReset = 1'b1;
            nxt.out.coreStall = 1'b1;
            nxt.out.sleeping = 1'b0;
            nxt.out.warmReset = 1'b0;
            nxt.out.resumeNext = 1'b0;
            nxt.out.vectorTake = 1'b0;
            nxt.firstSeen = 1'b0;
            nxt.secondSeen = 1'b0;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            st <= '0;
            st.mode <= ST_DELAY;
            st.reason <= WK_RESET;
            st.rstMeta <= 1'b1;
            st.rstSync <= 1'b1;
            st.prescale <= `WDG_PRESCALE_RST;
            st.rsp.hreadyout <= 1'b1;
            st.out.chipReset <= 1'b1;
            st.out.coreStall <= 1'b1;
        end else if (clockEnable) begin
            st <= nxt;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    timeout_reset_a: assert property (clockEnable && st.mode == ST_RUN && ovf && !pinLow
        |=> st.out.chipReset && st.out.timeoutFlag && st.prescale == `WDG_PRESCALE_RST)
        else $error("timeout in run did not reset chip");
    warm_reset_a: assert property (clockEnable && st.mode == ST_SLEEP && ovf && !pinLow
        |=> st.out.warmReset && !st.out.chipReset && st.out.timeoutFlag && st.out.powerdownFlag)
        else $error("timeout in sleep did not warm reset");
    sleep_entry_a: assert property (clockEnable && st.mode == ST_RUN && coreCmd.sleepInstr && !ovf && !pinLow
        |=> st.out.powerdownFlag && !st.out.timeoutFlag && st.wdtCount == 15'h0000 && st.out.sleeping)
        else $error("sleep entry flags wrong");
    disabled_quiet_a: assert property (WDT_DISABLE |-> !ovf)
        else $error("disabled watchdog overflowed");
    pin_clear_a: assert property (clockEnable && pinLow
        |=> st.mode == ST_PINRST && st.wdtCount == 15'h0000 && st.prescale == `WDG_PRESCALE_RST)
        else $error("pin reset did not clear watchdog");
    dual_clear_a: assert property (DUAL_CLEAR && kickClear
        |-> (st.firstSeen || coreCmd.kickFirst) && (st.secondSeen || coreCmd.kickSecond))
        else $error("dual clear took effect early");
    stall_hold_a: assert property ($rose(st.out.coreStall) |-> st.out.coreStall[*8])
        else $error("start-up stall too short");
    delay_end_a: assert property (clockEnable && st.mode == ST_DELAY && st.delayCnt == `WDG_STARTUP_LAST
        && !pinLow |=> st.mode == ST_RUN && !st.out.coreStall)
        else $error("start-up delay did not end at count");
    port_wake_a: assert property (clockEnable && st.mode == ST_SLEEP && portFall && !ovf && !pinLow
        |=> st.mode == ST_DELAY && st.reason == WK_PORT && !st.out.chipReset)
        else $error("port wake wrong");
    pending_int_a: assert property (clockEnable && st.mode == ST_SLEEP && !portFall && !ovf && !pinLow
        && !(|(intIn.req & st.armed)) |=> st.mode == ST_SLEEP)
        else $error("pending interrupt woke device");

    instr_halt_a: assert property (USE_INSTR && st.mode == ST_SLEEP |-> !tick)
        else $error("instruction clock ticked in sleep");
    delay_step_a: assert property (clockEnable && st.mode == ST_DELAY && st.delayCnt != `WDG_STARTUP_LAST
        && !pinLow |=> st.mode == ST_DELAY && st.out.coreStall && st.delayCnt == $past(st.delayCnt) + 10'h001)
        else $error("delay count did not step");
    delay_hold_a: assert property (st.mode == ST_DELAY |-> st.out.coreStall && st.wdtCount == 15'h0000)
        else $error("core not stalled in delay");
    wake_stall_a: assert property (clockEnable && st.mode == ST_SLEEP && (ovf || portFall || intWake)
        && !pinLow |=> st.mode == ST_DELAY && st.out.coreStall && !st.out.sleeping && st.delayCnt == 10'h000)
        else $error("wake did not start delay");
    vector_take_a: assert property (clockEnable && st.mode == ST_DELAY && st.delayCnt == `WDG_STARTUP_LAST
        && st.reason == WK_INT && |(st.wakeInt & intIn.enable) && !intIn.stackFull && !pinLow
        |=> st.out.vectorTake && !st.out.resumeNext)
        else $error("enabled interrupt wake did not vector");
    int_resume_a: assert property (clockEnable && st.mode == ST_DELAY && st.delayCnt == `WDG_STARTUP_LAST
        && st.reason == WK_INT && !(|(st.wakeInt & intIn.enable) && !intIn.stackFull) && !pinLow
        |=> st.out.resumeNext && !st.out.vectorTake)
        else $error("blocked interrupt wake did not resume");
    port_resume_a: assert property (clockEnable && st.mode == ST_DELAY && st.delayCnt == `WDG_STARTUP_LAST
        && st.reason == WK_PORT && !pinLow |=> st.out.resumeNext && !st.out.vectorTake)
        else $error("port wake did not resume");
    pulse_end_a: assert property (clockEnable && (st.out.resumeNext || st.out.vectorTake)
        |=> !st.out.resumeNext && !st.out.vectorTake)
        else $error("resume pulse too long");
    warm_pulse_a: assert property (clockEnable && st.out.warmReset |=> !st.out.warmReset)
        else $error("warm reset pulse too long");
    arm_mask_a: assert property (clockEnable && st.mode == ST_RUN && coreCmd.sleepInstr && !ovf && !pinLow
        |=> st.armed == ~$past(intIn.req))
        else $error("wake arming wrong");
    warm_keep_a: assert property (clockEnable && st.mode == ST_SLEEP && ovf && !pinLow
        && !(st.ahbValid && st.ahbWrite) |=> st.prescale == $past(st.prescale))
        else $error("warm reset changed prescale");
    pin_sleep_a: assert property (clockEnable && st.mode == ST_SLEEP && pinLow
        |=> !st.out.timeoutFlag && st.out.powerdownFlag)
        else $error("pin wake flags wrong");
    pin_delay_a: assert property (clockEnable && st.mode == ST_PINRST && !pinLow
        |=> st.mode == ST_DELAY && st.out.chipReset && st.delayCnt == 10'h000)
        else $error("pin release did not start delay");
    kick_clear_a: assert property (clockEnable && kickClear && !ovf && !pinLow && !coreCmd.sleepInstr
        |=> st.wdtCount == 15'h0000 && !st.out.timeoutFlag && !st.out.powerdownFlag)
        else $error("clear did not clear counter and flags");
    count_step_a: assert property (clockEnable && tick && (st.mode == ST_RUN || st.mode == ST_SLEEP)
        && !ovf && !kickClear && !pinLow && !(st.mode == ST_RUN && coreCmd.sleepInstr)
        && !(st.mode == ST_SLEEP && (portFall || intWake)) |=> st.wdtCount == $past(st.wdtCount) + 15'h0001)
        else $error("counter did not step on tick");
    sleep_level_a: assert property (st.mode == ST_SLEEP |-> st.out.sleeping)
        else $error("sleep level missing");
    status_read_a: assert property (clockEnable && addrPhase && addrHit && !ahbReq.hwrite
        && ahbReq.haddr[7:0] == `WDG_STATUS_ADDR |=> st.rsp.hrdata[`WDG_TO_BIT] == $past(st.out.timeoutFlag)
        && st.rsp.hrdata[`WDG_PD_BIT] == $past(st.out.powerdownFlag))
        else $error("status read data wrong");
    write_store_a: assert property (clockEnable && st.ahbValid && st.ahbWrite && st.ahbAddr == `WDG_PRESCALE_ADDR
        && !pinLow && !(st.mode == ST_RUN && ovf) |=> st.prescale == $past(ahbReq.hwdata[7:0]))
        else $error("prescale write lost");
    sync_rst_a: assert property (clockEnable |=> st.rstSync == $past(st.rstMeta))
        else $error("pin synchroniser skipped a stage");
    bus_okay_a: assert property (st.rsp.hreadyout && !st.rsp.hresp)
        else $error("bus response not ready okay");

    sleep_seen_c: cover property (st.mode == ST_SLEEP);
    warm_seen_c: cover property (st.out.warmReset);
    vector_seen_c: cover property (st.out.vectorTake);
    timeout_seen_c: cover property (st.mode == ST_RUN && ovf);
    int_wake_c: cover property (st.mode == ST_DELAY && st.reason == WK_INT);
endmodule
`default_nettype wire

//--- wdg_core_model.sv
// Processor core stand-in that issues clear and sleep instructions
`timescale 1ns/1ps
`default_nettype none
module wdg_core_model (
    input wire logic clock,
    input wire wdg_pkg::wdg_core_out_t coreOut,
    output var wdg_pkg::wdg_core_cmd_t coreCmd
);
    import wdg_pkg::*;
    initial coreCmd = '0;
    // A real core executes nothing while stalled or asleep, so wait that out first
    task automatic issue(input logic [3:0] cmd, input int gap);
        int n;
        n = 0;
        repeat (gap) @(posedge clock);
        while ((coreOut.coreStall !== 1'b0 || coreOut.sleeping !== 1'b0) && n < 5000) begin
            @(posedge clock);
            n++;
        end
        coreCmd <= cmd;
        @(posedge clock);
        coreCmd <= '0;
    endtask
endmodule
`default_nettype wire

//--- wdg_watchdog_test.sv
// Self-checking bench for the watchdog, sleep and reset-cause block
`timescale 1ns/1ps
`default_nettype none
module wdg_watchdog_test;
    import wdg_pkg::*;
    typedef struct {logic wr; logic [7:0] a; logic [31:0] d;} wdg_row_t;
    wdg_row_t rows[9] = '{'{0, 8'h00, 32'h07}, '{0, 8'h04, 32'h00}, '{1, 8'h00, 32'hf8}, '{0, 8'h00, 32'hf8},
        '{1, 8'h04, 32'hff}, '{0, 8'h04, 32'h00}, '{0, 8'h08, 32'h00}, '{1, 8'h00, 32'h08}, '{0, 8'h00, 32'h08}};
    logic clock, rst, extResetN, rcOsc;
    logic [7:0] portA;
    logic [31:0] rd;
    wdg_ahb_req_t ahbReq;
    wdg_ahb_rsp_t ahbRsp;
    wdg_int_t intIn;
    wdg_core_cmd_t coreCmd;
    wdg_core_out_t coreOut;
    int mismatches = 0;
    int comparisons = 0;
    int cycles = 0;
    int n;

    // Single slave, so its hreadyout is the bus hready
    wdg_watchdog #(.DUAL_CLEAR(1'b0)) u_dut (.clock(clock), .rst(rst), .clockEnable(1'b1),
        .ahbReq({ahbReq[$bits(wdg_ahb_req_t)-1:1], ahbRsp.hreadyout}),
        .ahbRsp(ahbRsp), .extResetN(extResetN), .watchdogRcOsc(rcOsc), .realtimeCrystalOsc(~rcOsc),
        .portA(portA), .coreCmd(coreCmd), .intIn(intIn), .coreOut(coreOut));
    wdg_core_model u_core (.clock(clock), .coreOut(coreOut), .coreCmd(coreCmd));

    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    // RC tick every 8 clocks, slow enough for the two-flop synchroniser
    initial begin
        rcOsc = 1'b0;
        forever #16 rcOsc = ~rcOsc;
    end

    task automatic results();
        if (mismatches == 0 && comparisons > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    always @(posedge clock) begin
        cycles++;
        if (cycles == 40000) begin
            mismatches++;
            results();
        end
    end

    task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rdv);
        ahbReq.hsel <= 1'b1;
        ahbReq.haddr <= {24'h000000, a};
        ahbReq.htrans <= 2'b10;
        ahbReq.hwrite <= wr;
        ahbReq.hsize <= 3'b010;
        do @(posedge clock); while (ahbRsp.hreadyout !== 1'b1);
        ahbReq.hsel <= 1'b0;
        ahbReq.htrans <= 2'b00;
        ahbReq.hwdata <= wd;
        do @(posedge clock); while (ahbRsp.hreadyout !== 1'b1);
        rdv = ahbRsp.hrdata;
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input string nm);
        logic [31:0] v;
        ahb(1'b0, a, 32'h00000000, v);
        check(nm, e, v);
    endtask

    function automatic logic pick(input int s);
        case (s)
            0: return coreOut.coreStall;
            2: return coreOut.chipReset;
            3: return coreOut.warmReset;
            4: return coreOut.resumeNext;
            5: return coreOut.vectorTake;
            default: return ~coreOut.chipReset;
        endcase
    endfunction

    // Bounded wait; a pulse missed here shows as a failed compare
    task automatic waitSig(input int s, input int lim, output int cnt);
        cnt = 0;
        while (pick(s) !== 1'b1 && cnt < lim) begin
            @(posedge clock);
            cnt++;
        end
        check("awaited output", 32'd1, 32'(pick(s)));
    endtask

    initial begin
        rst = 1'b1;
        extResetN = 1'b1;
        portA = 8'hff;
        intIn = '0;
        ahbReq = '0;
        ahbReq.hready = 1'b1;
        repeat (16) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        foreach (rows[i]) begin
            ahb(rows[i].wr, rows[i].a, rows[i].d, rd);
            if (!rows[i].wr) check("register read", rows[i].d, rd);
        end
        waitSig(6, 1100, n);
        repeat (1500) @(posedge clock);
        u_core.issue(4'b0100, 0);
        repeat (1500) @(posedge clock);
        check("chip reset before timeout", 32'd0, 32'(coreOut.chipReset));
        waitSig(2, 800, n);
        check("timeout after clear", 32'd1, 32'(n > 530 && n < 575));
        waitSig(6, 1100, n);
        check("start-up delay", 32'd1, 32'(n >= 1020 && n <= 1028));
        rdchk(8'h04, 32'h20, "status after run timeout");
        check("timeout flag output", 32'd1, 32'(coreOut.timeoutFlag));
        rdchk(8'h00, 32'h07, "prescale after run timeout");
        ahb(1'b1, 8'h00, 32'h00, rd);
        u_core.issue(4'b1000, 3);
        rdchk(8'h04, 32'h10, "status in sleep");
        check("asleep", 32'd1, 32'(coreOut.sleeping));
        check("power-down flag output", 32'd1, 32'(coreOut.powerdownFlag));
        portA <= 8'hfe;
        waitSig(0, 20, n);
        waitSig(4, 1100, n);
        check("wake delay", 32'd1024, n);
        portA <= 8'hff;
        u_core.issue(4'b0100, 2);
        rdchk(8'h04, 32'h00, "status after clear");
        intIn <= '{2'b01, 2'b01, 1'b0};
        u_core.issue(4'b1000, 2);
        repeat (200) @(posedge clock);
        check("pending request ignored", 32'd1, 32'(coreOut.sleeping));
        waitSig(3, 2100, n);
        check("sleep timeout", 32'd1, 32'(n > 1820 && n < 1880));
        check("no chip reset on warm", 32'd0, 32'(coreOut.chipReset));
        rdchk(8'h04, 32'h30, "status after warm wake");
        rdchk(8'h00, 32'h00, "prescale kept on warm");
        // Disabled, enabled, enabled with full stack
        for (int k = 0; k < 3; k++) begin
            intIn <= '{2'b00, (k == 0) ? 2'b00 : 2'b10, k == 2};
            u_core.issue(4'b1000, 2);
            @(posedge clock);
            intIn.req <= 2'b10;
            waitSig((k == 1) ? 5 : 4, 1200, n);
        end
        u_core.issue(4'b1000, 2);
        extResetN <= 1'b0;
        repeat (10) @(posedge clock);
        extResetN <= 1'b1;
        waitSig(6, 1200, n);
        rdchk(8'h04, 32'h10, "status after pin wake");
        rdchk(8'h00, 32'h07, "prescale after pin reset");
        rst <= 1'b1;
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        rdchk(8'h04, 32'h00, "status after power-up");
        results();
    end
endmodule
`default_nettype wire
